// File: fault_pkg.sv
package fault_pkg;

   // ***********************************************************
   // Widths and register offsets
   // ***********************************************************
   localparam int         DATA_W       = 32;
   localparam int         ADDR_W       = 8;
   localparam logic [7:0] OFS_COMBINED = 8'h28;
   localparam logic [7:0] OFS_HARD     = 8'h2c;
   localparam logic [7:0] OFS_MEM_ADDR = 8'h34;
   localparam logic [7:0] OFS_BUS_ADDR = 8'h38;
   localparam logic [7:0] OFS_AUX      = 8'h3c;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int MF_FETCH      = 0;
   localparam int MF_DATA       = 1;
   localparam int MF_UNSTACK    = 3;
   localparam int MF_STACK      = 4;
   localparam int MF_LAZY_FP    = 5;
   localparam int MF_ADDR_VALID = 7;
   localparam int BF_ADDR_VALID = 15;
   localparam int HF_VECTOR     = 1;
   localparam int HF_FORCED     = 30;
   localparam int HF_DEBUG      = 31;

   // ***********************************************************
   // Implemented bits and reset values
   // ***********************************************************
   localparam logic [7:0]  MEM_STATUS_MASK = 8'hbb;
   localparam logic [31:0] HARD_MASK       = 32'h4000_0002;
   localparam logic [7:0]  MEM_STATUS_RST  = 8'h00;
   localparam logic [31:0] HARD_RST        = 32'h0000_0000;
   localparam logic [31:0] AUX_RST         = 32'h0000_0000;
   localparam logic [31:0] ADDR_RST        = 32'h0000_0000;
   localparam logic [0:0]  BUS_VALID_RST   = 1'h0;

   // Fault causes reported by the exception logic.
   typedef enum logic [2:0] {
      FK_NONE        = 3'h0,
      FK_LAZY_FP     = 3'h1,
      FK_STACKING    = 3'h2,
      FK_UNSTACKING  = 3'h3,
      FK_DATA        = 3'h4,
      FK_FETCH       = 3'h5,
      FK_BUS_PRECISE = 3'h6,
      FK_VECTOR      = 3'h7
   } fault_kind_t;

   // Expands byte enables into a bit mask.
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // True for an aligned access; narrow lanes only where allowed.
   function automatic logic lanes_ok(input logic [1:0] low,
                                     input logic [3:0] be,
                                     input logic       narrow_ok);
      logic legal;
      legal = (be == 4'hf);
      if (narrow_ok) begin
         legal = legal || (be == 4'h1) || (be == 4'h2) || (be == 4'h4) ||
                 (be == 4'h8) || (be == 4'h3) || (be == 4'hc);
      end
      lanes_ok = (low == 2'h0) && legal;
   endfunction

endpackage

// File: fault_if.sv
`timescale 1ns/10ps
interface fault_if
   import fault_pkg::*;
();
   logic        ev_valid;     // One-cycle fault event.
   fault_kind_t ev_kind;      // Cause of the event.
   logic        ev_forced;    // Event escalated to hard fault.
   logic [31:0] ev_addr;      // Address that actually faulted.
   logic [31:0] ev_req_addr;  // Address the instruction requested.
   logic [31:0] aux_pulse;    // Side error pulses, one bit each.

   modport core (output ev_valid, ev_kind, ev_forced, ev_addr, ev_req_addr, aux_pulse);
   modport regs (input  ev_valid, ev_kind, ev_forced, ev_addr, ev_req_addr, aux_pulse);
endinterface

// File: sticky_w1c.sv
`timescale 1ns/10ps
module sticky_w1c #(
   parameter int               WIDTH = 32,
   parameter logic [WIDTH-1:0] RST   = '0
) (
   input  wire logic             clk_i,  // System clock.
   input  wire logic             rst_i,  // Synchronous reset.
   input  wire logic [WIDTH-1:0] set_i,  // Hardware set pulses.
   input  wire logic [WIDTH-1:0] clr_i,  // Software write-one clears.
   output logic      [WIDTH-1:0] q_o     // Flag state.
);

   logic [WIDTH-1:0] next_q;

   generate
      if (WIDTH < 1) begin : g_bad
         $error("sticky_w1c needs WIDTH of at least one.");
      end
   endgenerate

   // A set in the same cycle as a clear wins, so no event is lost.
   always_comb begin
      next_q = (q_o & ~clr_i) | set_i;
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= RST;
      end else begin
         q_o <= next_q;
      end
   end

endmodule

// File: core_fault_source.sv
`timescale 1ns/10ps
module core_fault_source
   import fault_pkg::*;
(
   input  wire logic        MCLK_I,            // System clock, 125 MHz.
   input  wire logic        SYS_RST_I,         // Synchronous reset, high.
   input  wire logic        FAULT_REQ_I,       // One-cycle fault detect.
   input  fault_kind_t      FAULT_KIND_I,      // Cause of the fault.
   input  wire logic [31:0] ACT_ADDR_I,        // Address that faulted.
   input  wire logic [31:0] REQ_ADDR_I,        // Address requested.
   input  wire logic [31:0] FAULT_PC_I,        // Faulting instruction PC.
   input  wire logic [31:0] PREEMPT_PC_I,      // Preempted instruction PC.
   input  wire logic        HANDLER_BLOCKED_I, // Priority blocks handler.
   input  wire logic        HANDLER_OFF_I,     // Handler disabled.
   input  wire logic [31:0] AUX_FAULT_I,       // Side error pulses.
   output logic             SP_ADJUST_O,       // Stack pointer moved.
   output logic             HARD_FAULT_O,      // Enter hard fault handler.
   output logic             OWN_HANDLER_O,     // Enter own fault handler.
   output logic      [31:0] STACK_PC_O,        // PC placed in the frame.
   fault_if.core            FLT                // Event link to registers.
);

   logic              next_valid;
   fault_kind_t       next_kind;
   logic              next_forced;
   logic              next_sp_adjust;
   logic              next_hard;
   logic              next_own;
   logic       [31:0] next_pc;
   logic              blocked;

   // ***********************************************************
   // Fault routing
   // ***********************************************************
   // Works out escalation, stack handling and the stacked PC.
   always_comb begin
      blocked        = HANDLER_BLOCKED_I | HANDLER_OFF_I;
      next_valid     = FAULT_REQ_I && (FAULT_KIND_I != FK_NONE);
      next_kind      = FAULT_REQ_I ? FAULT_KIND_I : FK_NONE;
      next_forced    = 1'b0;
      next_sp_adjust = next_valid;
      next_hard      = 1'b0;
      next_own       = 1'b0;
      next_pc        = STACK_PC_O;
      if (next_valid) begin
         next_pc = FAULT_PC_I;
         unique case (FAULT_KIND_I)
            FK_VECTOR: begin
               next_hard = 1'b1;
               next_pc   = PREEMPT_PC_I;
            end
            FK_UNSTACKING: begin
               next_sp_adjust = 1'b0;
               next_forced    = blocked;
               next_hard      = blocked;
               next_own       = !blocked;
            end
            default: begin
               next_forced = blocked;
               next_hard   = blocked;
               next_own    = !blocked;
            end
         endcase
      end
   end

   // ***********************************************************
   // Output and link registers
   // ***********************************************************
   // Everything leaves on flip-flops so the register side sees clean pulses.
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         FLT.ev_valid    <= 1'b0;
         FLT.ev_kind     <= FK_NONE;
         FLT.ev_forced   <= 1'b0;
         FLT.ev_addr     <= ADDR_RST;
         FLT.ev_req_addr <= ADDR_RST;
         FLT.aux_pulse   <= AUX_RST;
         SP_ADJUST_O     <= 1'b0;
         HARD_FAULT_O    <= 1'b0;
         OWN_HANDLER_O   <= 1'b0;
         STACK_PC_O      <= ADDR_RST;
      end else begin
         FLT.ev_valid    <= next_valid;
         FLT.ev_kind     <= next_kind;
         FLT.ev_forced   <= next_forced;
         FLT.ev_addr     <= ACT_ADDR_I;
         FLT.ev_req_addr <= REQ_ADDR_I;
         FLT.aux_pulse   <= AUX_FAULT_I;
         SP_ADJUST_O     <= next_sp_adjust;
         HARD_FAULT_O    <= next_hard;
         OWN_HANDLER_O   <= next_own;
         STACK_PC_O      <= next_pc;
      end
   end

endmodule

// File: fault_status_capture.sv
`timescale 1ns/10ps
module fault_status_capture
   import fault_pkg::*;
(
   input  wire logic        MCLK_I,             // System clock, 125 MHz.
   input  wire logic        SYS_RST_I,          // Synchronous reset, high.
   fault_if.regs            FLT,                // Events from the core.
   input  wire logic [7:0]  AVS_ADDRESS_I,      // Byte address in block.
   input  wire logic        AVS_READ_I,         // Read request.
   input  wire logic        AVS_WRITE_I,        // Write request.
   input  wire logic [31:0] AVS_WRITEDATA_I,    // Write data.
   input  wire logic [3:0]  AVS_BYTEENABLE_I,   // Byte lanes.
   output logic      [31:0] AVS_READDATA_O,     // Read data.
   output logic             AVS_WAITREQUEST_O   // Stall until answered.
);

   // ***********************************************************
   // Declarations
   // ***********************************************************
   logic        ack;
   logic        next_ack;
   logic [31:0] next_readdata;
   logic        wr_go;
   logic        sel_comb;
   logic        sel_hard;
   logic        sel_mem_addr;
   logic        sel_bus_addr;
   logic        sel_aux;
   logic        lanes_good;
   logic [31:0] wr_bits;
   logic [7:0]  mem_set;
   logic [7:0]  mem_clr;
   logic [7:0]  mem_status;
   logic [0:0]  bus_set;
   logic [0:0]  bus_clr;
   logic [0:0]  bus_valid;
   logic [31:0] hard_set;
   logic [31:0] hard_clr;
   logic [31:0] hard_status;
   logic [31:0] aux_clr;
   logic [31:0] aux_status;
   logic [31:0] mem_addr;
   logic [31:0] next_mem_addr;
   logic [31:0] bus_addr;
   logic [31:0] next_bus_addr;

   // ***********************************************************
   // Bus handshake and decode
   // ***********************************************************
   // One wait cycle per access; the data path has a flop on it.
   always_comb begin
      AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack;
      next_ack          = (AVS_READ_I | AVS_WRITE_I) & ~ack;
      wr_go             = AVS_WRITE_I & ack;
      sel_comb          = (AVS_ADDRESS_I[7:2] == OFS_COMBINED[7:2]);
      sel_hard          = (AVS_ADDRESS_I[7:2] == OFS_HARD[7:2]);
      sel_mem_addr      = (AVS_ADDRESS_I[7:2] == OFS_MEM_ADDR[7:2]);
      sel_bus_addr      = (AVS_ADDRESS_I[7:2] == OFS_BUS_ADDR[7:2]);
      sel_aux           = (AVS_ADDRESS_I[7:2] == OFS_AUX[7:2]);
      lanes_good        = lanes_ok(AVS_ADDRESS_I[1:0], AVS_BYTEENABLE_I, sel_comb);
      wr_bits           = wr_go && lanes_good ?
                          (AVS_WRITEDATA_I & lane_mask(AVS_BYTEENABLE_I)) : 32'h0000_0000;
   end

   // ***********************************************************
   // Fault event decode
   // ***********************************************************
   // Maps each core event onto the flags it sets.
   always_comb begin
      mem_set  = 8'h00;
      bus_set  = 1'b0;
      hard_set = 32'h0000_0000;
      if (FLT.ev_valid) begin
         unique case (FLT.ev_kind)
            FK_LAZY_FP:     mem_set[MF_LAZY_FP] = 1'b1;
            FK_STACKING:    mem_set[MF_STACK] = 1'b1;
            FK_UNSTACKING:  mem_set[MF_UNSTACK] = 1'b1;
            FK_DATA: begin
               mem_set[MF_DATA] = 1'b1;
               mem_set[MF_ADDR_VALID] = 1'b1;
            end
            FK_FETCH:       mem_set[MF_FETCH] = 1'b1;
            FK_BUS_PRECISE: bus_set = 1'b1;
            FK_VECTOR:      hard_set[HF_VECTOR] = 1'b1;
            default:        mem_set = 8'h00;
         endcase
         hard_set[HF_FORCED] = FLT.ev_forced;
      end
   end

   // ***********************************************************
   // Status flags
   // ***********************************************************
   // Software clears by writing ones; reserved bits never get a set.
   always_comb begin
      mem_clr  = sel_comb ? wr_bits[7:0] : 8'h00;
      bus_clr  = sel_comb ? wr_bits[BF_ADDR_VALID] : 1'b0;
      hard_clr = sel_hard ? (wr_bits & HARD_MASK) : 32'h0000_0000;
      aux_clr  = sel_aux ? wr_bits : 32'h0000_0000;
   end

   sticky_w1c #(
      .WIDTH (8),
      .RST   (MEM_STATUS_RST)
   ) u_mem_status (
      .clk_i (MCLK_I),
      .rst_i (SYS_RST_I),
      .set_i (mem_set & MEM_STATUS_MASK),
      .clr_i (mem_clr),
      .q_o   (mem_status)
   );

   sticky_w1c #(
      .WIDTH (1),
      .RST   (BUS_VALID_RST)
   ) u_bus_valid (
      .clk_i (MCLK_I),
      .rst_i (SYS_RST_I),
      .set_i (bus_set),
      .clr_i (bus_clr),
      .q_o   (bus_valid)
   );

   sticky_w1c #(
      .WIDTH (32),
      .RST   (HARD_RST)
   ) u_hard_status (
      .clk_i (MCLK_I),
      .rst_i (SYS_RST_I),
      .set_i (hard_set & HARD_MASK),
      .clr_i (hard_clr),
      .q_o   (hard_status)
   );

   // Side error bits feed no exception request; software polls or wires
   // a separate interrupt if it needs one.
   // pulse sets side bit
   sticky_w1c #(
      .WIDTH (32),
      .RST   (AUX_RST)
   ) u_aux_status (
      .clk_i (MCLK_I),
      .rst_i (SYS_RST_I),
      .set_i (FLT.aux_pulse),
      .clr_i (aux_clr),
      .q_o   (aux_status)
   );

   // ***********************************************************
   // Fault address registers
   // ***********************************************************
   // A capture beats a software write in the same cycle, since the
   // hardware address is the one a handler must see.
   always_comb begin
      next_mem_addr = mem_addr;
      next_bus_addr = bus_addr;
      if (sel_mem_addr && wr_go && lanes_good) begin
         next_mem_addr = AVS_WRITEDATA_I;
      end
      if (sel_bus_addr && wr_go && lanes_good) begin
         next_bus_addr = AVS_WRITEDATA_I;
      end
      if (FLT.ev_valid && (FLT.ev_kind == FK_DATA)) begin
         next_mem_addr = FLT.ev_addr;
      end
      if (FLT.ev_valid && (FLT.ev_kind == FK_BUS_PRECISE)) begin
         next_bus_addr = FLT.ev_req_addr;
      end
   end

   // ***********************************************************
   // Read data
   // ***********************************************************
   // Unmapped or refused reads answer zero.
   always_comb begin
      next_readdata = AVS_READDATA_O;
      if (AVS_READ_I && !ack) begin
         next_readdata = 32'h0000_0000;
         if (lanes_good) begin
            if (sel_comb) begin
               next_readdata = {16'h0000, bus_valid, 7'h00, mem_status & MEM_STATUS_MASK};
            end else if (sel_hard) begin
               next_readdata = hard_status & HARD_MASK;
            end else if (sel_mem_addr) begin
               next_readdata = mem_addr;
            end else if (sel_bus_addr) begin
               next_readdata = bus_addr;
            end else if (sel_aux) begin
               next_readdata = aux_status;
            end
         end
      end
   end

   // ***********************************************************
   // Registers
   // ***********************************************************
   // Handshake, read data and address registers.
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ack            <= 1'b0;
         AVS_READDATA_O <= 32'h0000_0000;
         mem_addr       <= ADDR_RST;
         bus_addr       <= ADDR_RST;
      end else begin
         ack            <= next_ack;
         AVS_READDATA_O <= next_readdata;
         mem_addr       <= next_mem_addr;
         bus_addr       <= next_bus_addr;
      end
   end

endmodule

// File: fault_properties.sv
`timescale 1ns/10ps
module fault_properties
   import fault_pkg::*;
(
   input  wire logic        MCLK_I,            // Clock.
   input  wire logic        SYS_RST_I,         // Reset.
   input  wire logic        FAULT_REQ_I,       // Fault detect.
   input  fault_kind_t      FAULT_KIND_I,      // Fault cause.
   input  wire logic [31:0] ACT_ADDR_I,        // Faulting address.
   input  wire logic [31:0] REQ_ADDR_I,        // Requested address.
   input  wire logic        HANDLER_BLOCKED_I, // Handler blocked.
   input  wire logic        HANDLER_OFF_I,     // Handler off.
   input  wire logic [31:0] AUX_FAULT_I,       // Side pulses in.
   input  wire logic        ev_valid,          // Event strobe.
   input  fault_kind_t      ev_kind,           // Event cause.
   input  wire logic        ev_forced,         // Escalated event.
   input  wire logic [31:0] ev_addr,           // Actual address.
   input  wire logic [31:0] ev_req_addr,       // Requested address.
   input  wire logic [31:0] aux_pulse          // Side pulses out.
);
   // One domain, so clock and reset are given once for every property.
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);

   a_event_follows : assert property (FAULT_REQ_I && FAULT_KIND_I != FK_NONE |=>
      ev_valid && ev_kind == $past(FAULT_KIND_I)) else $error("event lost");
   a_quiet_no_req : assert property (!FAULT_REQ_I |=> !ev_valid)
      else $error("event without request");
   a_fetch_event : assert property (FAULT_REQ_I && FAULT_KIND_I == FK_FETCH |=>
      ev_valid && ev_kind == FK_FETCH) else $error("fetch event lost");
   a_actual_addr : assert property (FAULT_REQ_I && FAULT_KIND_I == FK_DATA |=>
      ev_addr == $past(ACT_ADDR_I)) else $error("wrong actual address");
   a_req_addr : assert property (FAULT_REQ_I && FAULT_KIND_I == FK_BUS_PRECISE |=>
      ev_req_addr == $past(REQ_ADDR_I)) else $error("wrong requested address");
   a_forced_escalate : assert property (FAULT_REQ_I &&
      !(FAULT_KIND_I inside {FK_NONE, FK_VECTOR}) |=>
      ev_forced == $past(HANDLER_BLOCKED_I || HANDLER_OFF_I)) else $error("bad escalation");
   a_vector_plain : assert property (FAULT_REQ_I && FAULT_KIND_I == FK_VECTOR |=>
      ev_valid && !ev_forced) else $error("vector fault forced");
   a_side_passes : assert property (1'b1 |=> aux_pulse == $past(AUX_FAULT_I))
      else $error("side pulse lost");
endmodule

// File: tb.sv
`timescale 1ns/10ps
module tb
   import fault_pkg::*;
;
   logic        mclk, sys_rst, req, blk, off, rd, wr, wait_o;
   logic        sp_adj, hard_o, own_o, m_bv;
   fault_kind_t kind;
   logic [31:0] act, rqa, fpc, ppc, aux_in, stack_pc, wdata, rdata, q;
   logic [31:0] m_hard, m_maddr, m_baddr, m_aux;
   logic [7:0]  addr, m_ms;
   logic [3:0]  be;
   int          error_cnt, checks, cyc;
   integer      seed;
   // Address registers come before status, as a fault handler reads them.
   logic [7:0]  ofs [5] = '{OFS_MEM_ADDR, OFS_BUS_ADDR, OFS_COMBINED, OFS_HARD, OFS_AUX};
   logic [31:0] wmsk [5] = '{32'hffffffff, 32'hffffffff, 32'h000080bb, HARD_MASK, 32'hffffffff};
   logic [7:0]  na [7] = '{8'h28, 8'h28, 8'h28, 8'h29, 8'h34, 8'h28, 8'h2c};
   logic [3:0]  nb [7] = '{4'h1, 4'h1, 4'h2, 4'hf, 4'h1, 4'h5, 4'h3};
   logic [31:0] nd [7] = '{32'h8000, 32'h80, 32'h8000, 32'hff, 32'h0, 32'hff, 32'h2};

   fault_if u_fault_if ();
   core_fault_source u_core_fault_source (.MCLK_I(mclk), .SYS_RST_I(sys_rst),
      .FAULT_REQ_I(req), .FAULT_KIND_I(kind), .ACT_ADDR_I(act), .REQ_ADDR_I(rqa),
      .FAULT_PC_I(fpc), .PREEMPT_PC_I(ppc), .HANDLER_BLOCKED_I(blk), .HANDLER_OFF_I(off),
      .AUX_FAULT_I(aux_in), .SP_ADJUST_O(sp_adj), .HARD_FAULT_O(hard_o),
      .OWN_HANDLER_O(own_o), .STACK_PC_O(stack_pc), .FLT(u_fault_if));
   fault_status_capture u_fault_status_capture (.MCLK_I(mclk), .SYS_RST_I(sys_rst),
      .FLT(u_fault_if), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(wait_o));
   fault_properties u_fault_properties (.MCLK_I(mclk), .SYS_RST_I(sys_rst),
      .FAULT_REQ_I(req), .FAULT_KIND_I(kind), .ACT_ADDR_I(act), .REQ_ADDR_I(rqa),
      .HANDLER_BLOCKED_I(blk), .HANDLER_OFF_I(off), .AUX_FAULT_I(aux_in),
      .ev_valid(u_fault_if.ev_valid), .ev_kind(u_fault_if.ev_kind),
      .ev_forced(u_fault_if.ev_forced), .ev_addr(u_fault_if.ev_addr),
      .ev_req_addr(u_fault_if.ev_req_addr), .aux_pulse(u_fault_if.aux_pulse));

   // Free-running 125 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // A hang is cut short here, long after the tests should have ended.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   function automatic logic [31:0] lanes(input logic [3:0] b);
      return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
   endfunction

   // Narrow lanes are legal on the combined status word only, never unaligned.
   function automatic logic legal(input logic [7:0] a, input logic [3:0] b);
      return a[1:0] == 2'h0 && (b == 4'hf || (a == OFS_COMBINED &&
             b inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc}));
   endfunction

   function automatic logic [31:0] exp_rd(input logic [7:0] a, input logic [3:0] b);
      logic [31:0] v;
      case (a)
         OFS_COMBINED: v = {16'h0, m_bv, 7'h0, m_ms};
         OFS_HARD:     v = m_hard;
         OFS_MEM_ADDR: v = m_maddr;
         OFS_BUS_ADDR: v = m_baddr;
         OFS_AUX:      v = m_aux;
         default:      v = 32'h0;
      endcase
      return legal(a, b) ? v & lanes(b) : 32'h0;
   endfunction

   // The request is held until the edge that samples waitrequest low.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      be <= b;
      rd <= ~w;
      wr <= w;
      // At each rising edge the bench sees what stood before it, as the slave does.
      do begin
         @(posedge mclk);
      end while (wait_o !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      bus(1'b1, a, d, b);
      if (legal(a, b)) begin
         case (a)
            OFS_COMBINED: begin
               m_ms = m_ms & ~(d[7:0] & {8{b[0]}});
               m_bv = m_bv & ~(d[15] & b[1]);
            end
            OFS_HARD:     m_hard = m_hard & ~d;
            OFS_MEM_ADDR: m_maddr = d;
            OFS_BUS_ADDR: m_baddr = d;
            OFS_AUX:      m_aux = m_aux & ~d;
            default:      m_aux = m_aux;
         endcase
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [3:0] b);
      bus(1'b0, a, 32'h0, b);
      chk($sformatf("reg_%h_lanes_%h", a, b), q & lanes(b), exp_rd(a, b));
   endtask

   task automatic check_all();
      for (int j = 0; j < 5; j++) begin
         rd_chk(ofs[j], 4'hf);
      end
   endtask

   // One-cycle fault request, then entry outputs and register model.
   task automatic fault(input fault_kind_t k, input logic b, input logic o);
      logic fo;
      @(posedge mclk);
      req <= 1'b1;
      kind <= k;
      blk <= b;
      off <= o;
      act <= $random(seed);
      rqa <= $random(seed);
      fpc <= $random(seed);
      ppc <= $random(seed);
      @(posedge mclk);
      req <= 1'b0;
      @(negedge mclk);
      fo = !(k inside {FK_NONE, FK_VECTOR}) && (b || o);
      chk("hard_entry", hard_o, fo || k == FK_VECTOR);
      chk("own_entry", own_o, !fo && !(k inside {FK_NONE, FK_VECTOR}));
      if (k == FK_VECTOR) chk("stack_pc", stack_pc, ppc);
      if (k inside {FK_DATA, FK_FETCH}) chk("stack_pc", stack_pc, fpc);
      if (k == FK_STACKING) chk("sp_adjust", sp_adj, 1'b1);
      if (k == FK_UNSTACKING) chk("sp_adjust", sp_adj, 1'b0);
      case (k)
         FK_LAZY_FP:     m_ms[5] = 1'b1;
         FK_STACKING:    m_ms[4] = 1'b1;
         FK_UNSTACKING:  m_ms[3] = 1'b1;
         FK_DATA:        {m_ms[7], m_ms[1], m_maddr} = {2'h3, act};
         FK_FETCH:       m_ms[0] = 1'b1;
         FK_BUS_PRECISE: {m_bv, m_baddr} = {1'b1, rqa};
         FK_VECTOR:      m_hard[1] = 1'b1;
         default:        m_hard = m_hard;
      endcase
      if (fo) m_hard[30] = 1'b1;
   endtask

   task automatic side(input logic [31:0] p);
      @(posedge mclk);
      aux_in <= p;
      @(posedge mclk);
      aux_in <= 32'h0;
      @(negedge mclk);
      chk("side_no_entry", {hard_o, own_o}, 32'h0);
      m_aux = m_aux | p;
   endtask

   // Main sequence: reset, every cause, a random mix, then narrow and refused accesses.
   initial begin
      int k;
      {req, blk, off, rd, wr, m_bv, addr, be, m_ms} = '0;
      {act, rqa, fpc, ppc, aux_in, wdata, m_hard, m_maddr, m_baddr, m_aux} = '0;
      {error_cnt, checks, cyc} = '0;
      kind = FK_NONE;
      seed = 32'h9322b4cc;
      sys_rst = 1'b1;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      check_all();
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         fault(fault_kind_t'(i[2:0]), i[3], 1'($random(seed)));
         check_all();
      end
      $display("test causes done");
      for (int i = 0; i < 80; i++) begin
         k = {$random(seed)} % 5;
         case ({$random(seed)} % 3)
            0: fault(fault_kind_t'(3'($random(seed))), 1'($random(seed)), 1'($random(seed)));
            1: side($random(seed));
            default: wr_reg(ofs[k], $random(seed) & wmsk[k], 4'hf);
         endcase
      end
      check_all();
      $display("test random done");
      fault(FK_DATA, 1'b0, 1'b0);
      fault(FK_BUS_PRECISE, 1'b0, 1'b0);
      rd_chk(OFS_COMBINED, 4'h1);
      rd_chk(OFS_COMBINED, 4'h3);
      for (int i = 0; i < 7; i++) begin
         wr_reg(na[i], nd[i], nb[i]);
         check_all();
      end
      rd_chk(8'h40, 4'hf);
      $display("test narrow done");
      print_verdict();
   end
endmodule
